/* File: hdl/rsi_top.sv */
// Notes on behaviour
// - Readings enter the store at full converter rate; destination is signalled.
// - Interrupt goes to mainframe or parallel I/O controller per target select.
// - Data-available policy interrupts on any stored reading; no overwrite.
// - Burst policy interrupts when room for 4096 more readings; no overwrite.
// - Complete policy interrupts at scan end; old readings may be overwritten.
// - End policy interrupts at scan end or store full; no overwrite.
// - End policy with reading count above capacity aborts the scan.
// - Nothing reaches IRQ_MAIN, IRQ_PIO or SRQ until interrupts are enabled; IRQ follows status and mask alone.
// - Mainframe service request needs mask bit of weight 512.
// - Reading data out of the store clears the pending interrupt.
// - Query returns lowest interrupting slot, or minus one when none.
// - Disable command, or a target or policy change without the enable bit in the same write, disables interrupts.
// - Configure phase precedes measuring; later writes override bulk defaults.
//
// Implementation choices: the strobed register port and the address map.
`include "rsi_cfg.svh"
module rsi_top
	import rsi_pkg::*;
#(
	parameter int DEPTH = 8192,
	parameter int RW = 16,
	parameter int NSLOT = 8,
	parameter int OWN_SLOT = 6
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic RDG_VALID,
	input wire logic [RW-1:0] RDG_DATA,
	input wire logic SCAN_DONE,
	input wire logic [NSLOT-1:0] SLOT_IRQ,
	output logic IRQ_MAIN,
	output logic IRQ_PIO,
	output logic SRQ,
	output logic IRQ
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ROOM_C = CW'(`RSI_BURST_ROOM);

	function automatic logic [7:0] lowest_slot(input logic [NSLOT-1:0] v);
		logic [7:0] r;
		r = `RSI_NO_SLOT;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 8'(i);
			end
		end
		return r;
	endfunction

	logic [RW-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [CW-1:0] cnt_q, cnt_d, cap;
	rsi_policy_t pol_q, pol_d;
	rsi_target_t tgt_q, tgt_d;
	rsi_phase_t ph_q, ph_d;
	logic en_q, en_d, pend_q, pend_d;
	logic [15:0] nrdg_q, nrdg_d, pre_q, pre_d, post_q, post_d, srqm_q, srqm_d;
	logic [`RSI_NEV-1:0] istat_q, istat_d, imask_q, imask_d, ev;
	logic [NSLOT-1:0] slot_s1_q, slot_s2_q, slots;
	logic [31:0] rdata_q, rdata_d;
	logic irq_main_q, irq_main_d, irq_pio_q, irq_pio_d, srq_q, srq_d, irq_q, irq_d;
	logic [16:0] win;
	logic full, empty, push, pop, drop_old, done_ev, abort, cond, ctl_wr, chg;
	logic empty_d, full_d;

	assign RDATA = rdata_q;
	assign IRQ_MAIN = irq_main_q;
	assign IRQ_PIO = irq_pio_q;
	assign SRQ = srq_q;
	assign IRQ = irq_q;

	// In complete mode a nonzero pre plus post window below the store depth caps the store, so older readings roll out.
	always_comb begin
		win = 17'(pre_q) + 17'(post_q);
		cap = DEPTH_C;
		if (pol_q == POL_COMPLETE && win != 17'h0_0000 && 32'(win) < DEPTH) begin
			cap = CW'(win);
		end
	end

	assign full = cnt_q >= cap;
	assign empty = cnt_q == '0;
	assign ctl_wr = WR && ADDR == `RSI_OFS_CTRL;
	assign pop = RD && ADDR == `RSI_OFS_DATA && !empty;
	assign done_ev = SCAN_DONE && ph_q == PH_MEASURE;
	assign abort = ctl_wr && WDATA[`RSI_CTRL_START] && ph_q == PH_CONFIG && pol_q == POL_END &&
		32'(nrdg_q) > DEPTH;

	// Readings are taken every cycle so the store keeps pace with the converter.
	always_comb begin
		push = RDG_VALID && ph_q == PH_MEASURE && (!full || pol_q == POL_COMPLETE);
		drop_old = push && full && !pop;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_ptr_d = AW'(wr_ptr_q + 1'b1);
		end
		if (pop || drop_old) begin
			rd_ptr_d = AW'(rd_ptr_q + 1'b1);
		end
		if (push && !(pop || drop_old)) begin
			cnt_d = CW'(cnt_q + 1'b1);
		end else if (!push && pop) begin
			cnt_d = CW'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (CE && push) begin
			mem[wr_ptr_q] <= RDG_DATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else if (CE) begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_d;
		end
	end

	// Reading count, pre and post writes and bulk defaults are refused while a scan is measuring.
	always_comb begin
		pol_d = pol_q;
		tgt_d = tgt_q;
		ph_d = ph_q;
		en_d = en_q;
		nrdg_d = nrdg_q;
		pre_d = pre_q;
		post_d = post_q;
		srqm_d = srqm_q;
		imask_d = imask_q;
		chg = 1'b0;
		if (ctl_wr) begin
			pol_d = rsi_policy_t'(WDATA[`RSI_CTRL_POL+:2]);
			tgt_d = rsi_target_t'(WDATA[`RSI_CTRL_TGT]);
			chg = pol_d != pol_q || tgt_d != tgt_q;
			if (chg) begin
				en_d = 1'b0;
			end
			if (WDATA[`RSI_CTRL_EN]) begin
				en_d = 1'b1;
			end
			if (WDATA[`RSI_CTRL_DIS]) begin
				en_d = 1'b0;
			end
			if (WDATA[`RSI_CTRL_BULK] && ph_q == PH_CONFIG) begin
				nrdg_d = `RSI_DEF_NRDG;
				pre_d = `RSI_DEF_PRE;
				post_d = `RSI_DEF_POST;
			end
		end
		case (ph_q)
			PH_CONFIG: begin
				if (ctl_wr && WDATA[`RSI_CTRL_START] && !abort) begin
					ph_d = PH_MEASURE;
				end
			end
			PH_MEASURE: begin
				if (SCAN_DONE) begin
					ph_d = PH_CONFIG;
				end
			end
			default: begin
				ph_d = PH_CONFIG;
			end
		endcase
		if (WR && ph_q == PH_CONFIG && !(ctl_wr && WDATA[`RSI_CTRL_BULK])) begin
			if (ADDR == `RSI_OFS_NRDG) begin
				nrdg_d = WDATA[15:0];
			end else if (ADDR == `RSI_OFS_PRE) begin
				pre_d = WDATA[15:0];
			end else if (ADDR == `RSI_OFS_POST) begin
				post_d = WDATA[15:0];
			end
		end
		if (WR && ADDR == `RSI_OFS_SRQM) begin
			srqm_d = WDATA[15:0];
		end
		if (WR && ADDR == `RSI_OFS_IMASK) begin
			imask_d = WDATA[`RSI_NEV-1:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pol_q <= POL_DATA_AVAIL;
			tgt_q <= TGT_MAIN;
			ph_q <= PH_CONFIG;
			en_q <= 1'b0;
			nrdg_q <= `RSI_DEF_NRDG;
			pre_q <= `RSI_DEF_PRE;
			post_q <= `RSI_DEF_POST;
			srqm_q <= `RSI_DEF_SRQM;
			imask_q <= '0;
		end else if (CE) begin
			pol_q <= pol_d;
			tgt_q <= tgt_d;
			ph_q <= ph_d;
			en_q <= en_d;
			nrdg_q <= nrdg_d;
			pre_q <= pre_d;
			post_q <= post_d;
			srqm_q <= srqm_d;
			imask_q <= imask_d;
		end
	end

	// A new cause in the same cycle as a pop or a status-bit clear wins, so no event is lost; a disable in that cycle still clears pending.
	// Causes are judged on the count as it stands after this edge, so the pop that empties
	// the store is not undone by the old level of the count.
	always_comb begin
		empty_d = cnt_d == '0;
		full_d = cnt_d >= cap;
		case (pol_q)
			POL_DATA_AVAIL: begin
				cond = !empty_d;
			end
			POL_BURST: begin
				cond = (DEPTH_C - cnt_d) >= ROOM_C;
			end
			POL_COMPLETE: begin
				cond = done_ev;
			end
			POL_END: begin
				cond = done_ev || full_d || abort;
			end
			default: begin
				cond = 1'b0;
			end
		endcase
		pend_d = pend_q;
		if (pop || !en_d) begin
			pend_d = 1'b0;
		end
		if (en_d && cond) begin
			pend_d = 1'b1;
		end
		irq_main_d = en_d && pend_d && tgt_d == TGT_MAIN;
		irq_pio_d = en_d && pend_d && tgt_d == TGT_PIO;
		srq_d = irq_main_d && srqm_d[`RSI_SLOT_BIT];
		ev = '0;
		ev[`RSI_EV_PEND] = pend_d && !pend_q;
		ev[`RSI_EV_DONE] = done_ev;
		ev[`RSI_EV_FULL] = full_d && !full;
		ev[`RSI_EV_ABORT] = abort;
		istat_d = istat_q;
		if (WR && ADDR == `RSI_OFS_ISTAT) begin
			istat_d = istat_q & ~WDATA[`RSI_NEV-1:0];
		end
		istat_d = istat_d | ev;
		irq_d = |(istat_d & imask_d);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pend_q <= 1'b0;
			istat_q <= '0;
			irq_main_q <= 1'b0;
			irq_pio_q <= 1'b0;
			srq_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (CE) begin
			pend_q <= pend_d;
			istat_q <= istat_d;
			irq_main_q <= irq_main_d;
			irq_pio_q <= irq_pio_d;
			srq_q <= srq_d;
			irq_q <= irq_d;
		end
	end

	// Other slots raise their interrupts on pins, so they are synchronised first.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			slot_s1_q <= '0;
			slot_s2_q <= '0;
		end else if (CE) begin
			slot_s1_q <= SLOT_IRQ;
			slot_s2_q <= slot_s1_q;
		end
	end

	always_comb begin
		slots = slot_s2_q;
		slots[OWN_SLOT] = slot_s2_q[OWN_SLOT] || (en_q && pend_q);
	end

	// Reading the data word pops one reading; an empty store reads zero and pops nothing.
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (RD) begin
			if (ADDR == `RSI_OFS_CTRL) begin
				rdata_d[`RSI_CTRL_POL+:2] = pol_q;
				rdata_d[`RSI_CTRL_TGT] = tgt_q;
				rdata_d[`RSI_CTRL_ENQ] = en_q;
				rdata_d[`RSI_CTRL_PH+:2] = ph_q;
			end else if (ADDR == `RSI_OFS_STATUS) begin
				rdata_d[CW-1:0] = cnt_q;
				rdata_d[`RSI_ST_PEND] = pend_q;
				rdata_d[`RSI_ST_FULL] = full;
				rdata_d[`RSI_ST_EMPTY] = empty;
			end else if (ADDR == `RSI_OFS_DATA) begin
				if (!empty) begin
					rdata_d[RW-1:0] = mem[rd_ptr_q];
				end
			end else if (ADDR == `RSI_OFS_QUERY) begin
				rdata_d[7:0] = lowest_slot(slots);
			end else if (ADDR == `RSI_OFS_NRDG) begin
				rdata_d[15:0] = nrdg_q;
			end else if (ADDR == `RSI_OFS_PRE) begin
				rdata_d[15:0] = pre_q;
			end else if (ADDR == `RSI_OFS_POST) begin
				rdata_d[15:0] = post_q;
			end else if (ADDR == `RSI_OFS_SRQM) begin
				rdata_d[15:0] = srqm_q;
			end else if (ADDR == `RSI_OFS_ISTAT) begin
				rdata_d[`RSI_NEV-1:0] = istat_q;
			end else if (ADDR == `RSI_OFS_IMASK) begin
				rdata_d[`RSI_NEV-1:0] = imask_q;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			rdata_q <= 32'h0000_0000;
		end else if (CE) begin
			rdata_q <= rdata_d;
		end
	end
endmodule // rsi_top

/* File: hdl/rsi_cfg.svh */
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH
`define RSI_OFS_CTRL 8'h00
`define RSI_OFS_STATUS 8'h04
`define RSI_OFS_DATA 8'h08
`define RSI_OFS_QUERY 8'h0C
`define RSI_OFS_NRDG 8'h10
`define RSI_OFS_PRE 8'h14
`define RSI_OFS_POST 8'h18
`define RSI_OFS_SRQM 8'h1C
`define RSI_OFS_ISTAT 8'h20
`define RSI_OFS_IMASK 8'h24
`define RSI_CTRL_POL 0
`define RSI_CTRL_TGT 2
`define RSI_CTRL_ENQ 3
`define RSI_CTRL_EN 4
`define RSI_CTRL_DIS 5
`define RSI_CTRL_BULK 6
`define RSI_CTRL_START 7
`define RSI_CTRL_PH 8
`define RSI_ST_PEND 16
`define RSI_ST_FULL 17
`define RSI_ST_EMPTY 18
`define RSI_EV_PEND 0
`define RSI_EV_DONE 1
`define RSI_EV_FULL 2
`define RSI_EV_ABORT 3
`define RSI_NEV 4
`define RSI_SLOT_BIT 9
`define RSI_BURST_ROOM 4096
`define RSI_MAX_RATE 100000
`define RSI_NO_SLOT 8'hFF
`define RSI_DEF_NRDG 16'h0001
`define RSI_DEF_PRE 16'h0000
`define RSI_DEF_POST 16'h0000
`define RSI_DEF_SRQM 16'h0000
`endif

/* File: hdl/rsi_pkg.sv */
package rsi_pkg;
	typedef enum logic [1:0] {
		POL_DATA_AVAIL = 2'h0,
		POL_BURST = 2'h1,
		POL_COMPLETE = 2'h2,
		POL_END = 2'h3
	} rsi_policy_t;
	typedef enum logic {
		TGT_MAIN = 1'h0,
		TGT_PIO = 1'h1
	} rsi_target_t;
	typedef enum logic [1:0] {
		PH_CONFIG = 2'h1,
		PH_MEASURE = 2'h2
	} rsi_phase_t;
endpackage

/* File: verif/rsi_props.sv */
module rsi_props #(
	parameter int NSLOT = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [NSLOT-1:0] SLOT_IRQ,
	input wire logic IRQ_MAIN,
	input wire logic IRQ_PIO,
	input wire logic SRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	logic ctl;
	logic en_q;
	logic en_d;
	logic [2:0] cfg_q;
	logic [2:0] cfg_d;
	// The enable state is mirrored here, so the gating is judged without the design's internals.
	assign ctl = CE && WR && ADDR == 8'h00;
	always_comb begin
		cfg_d = ctl ? WDATA[2:0] : cfg_q;
		en_d = en_q;
		if (RESET) begin
			cfg_d = 3'h0;
			en_d = 1'b0;
		end else if (ctl) begin
			en_d = !WDATA[5] && (WDATA[4] || (en_q && WDATA[2:0] == cfg_q));
		end
	end
	always_ff @(posedge CLK_SYS) begin
		cfg_q <= cfg_d;
		en_q <= en_d;
	end
	tgt_excl_a: assert property (!(IRQ_MAIN && IRQ_PIO)) else $error("both targets raised");
	srq_gate_a: assert property (SRQ |-> IRQ_MAIN) else $error("request without main interrupt");
	rdata_idle_a: assert property ($past(CE) && !$past(RD) |-> RDATA == 32'h0000_0000) else $error("stray read data");
	dis_clear_a: assert property (ctl && WDATA[5] |=> !IRQ_MAIN && !IRQ_PIO) else $error("disable ignored");
	chg_clear_a: assert property (ctl && !WDATA[4] && WDATA[2:0] != cfg_q |=> !IRQ_MAIN && !IRQ_PIO)
		else $error("setting change kept interrupt");
	en_gate_a: assert property (!en_q |-> !IRQ_MAIN && !IRQ_PIO) else $error("interrupt while disabled");
	pend_hold_a: assert property (IRQ_MAIN && !(RD && ADDR == 8'h08) && !(WR && ADDR == 8'h00) |=> IRQ_MAIN)
		else $error("pending dropped");
	query_none_a: assert property (CE && RD && ADDR == 8'h0C && !IRQ_MAIN && !IRQ_PIO && SLOT_IRQ == '0
		&& $past(SLOT_IRQ) == '0 && $past(SLOT_IRQ, 2) == '0 |=> RDATA == 32'h0000_00FF) else $error("query not idle");
	cover property (IRQ_MAIN && SRQ);
	cover property (IRQ_PIO);
	cover property ($rose(IRQ_MAIN));
endmodule // rsi_props

bind rsi_top rsi_props #(.NSLOT(NSLOT)) u_props (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .SLOT_IRQ(SLOT_IRQ), .IRQ_MAIN(IRQ_MAIN), .IRQ_PIO(IRQ_PIO), .SRQ(SRQ));

/* File: verif/rsi_host.sv */
module rsi_host (
	input wire logic clk,
	input wire logic [7:0] want,
	input wire logic srq,
	output logic [7:0] slot_irq,
	output int n_srq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial slot_irq = 8'h00;
	initial n_srq = 0;
	// Other slots move their lines just after an edge, as unrelated pins would.
	always @(posedge clk) slot_irq <= want;
	// The controller hears only requests that the service mask let through.
	always @(posedge clk) if (srq) n_srq <= n_srq + 1;
endmodule // rsi_host

/* File: verif/reading_store_interrupt_logic_test.sv */
module reading_store_interrupt_logic_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] e;} rsi_row_t;
	logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, rv = 0, sd = 0;
	logic [7:0] addr = 0, want = 0, slot;
	logic [31:0] wd = 0, rdata;
	logic [15:0] rdg = 0;
	logic irq_main, irq_pio, srq, irq;
	int n_errors = 0, cmp_count = 0, cyc = 0, n_srq;
	rsi_row_t rows[11] = '{'{8'h00, 32'h0000_0100}, '{8'h04, 32'h0004_0000}, '{8'h08, 32'h0000_0000},
		'{8'h0C, 32'h0000_00FF}, '{8'h10, 32'h0000_0001}, '{8'h14, 32'h0000_0000}, '{8'h18, 32'h0000_0000},
		'{8'h1C, 32'h0000_0000}, '{8'h20, 32'h0000_0000}, '{8'h24, 32'h0000_0000}, '{8'h30, 32'h0000_0000}};
	always #12.5 clk = ~clk;
	rsi_top u_dut (.CLK_SYS(clk), .RESET(rst), .CE(ce), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata),
		.RDG_VALID(rv), .RDG_DATA(rdg), .SCAN_DONE(sd), .SLOT_IRQ(slot), .IRQ_MAIN(irq_main), .IRQ_PIO(irq_pio),
		.SRQ(srq), .IRQ(irq));
	rsi_host u_host (.clk(clk), .want(want), .srq(srq), .slot_irq(slot), .n_srq(n_srq));
	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	// Outputs are registered, so two edges are allowed before judging them.
	task automatic outs(input logic [3:0] e);
		repeat (2) @(posedge clk);
		#1 chk({28'h0, irq_main, irq_pio, srq, irq}, {28'h0, e});
	endtask
	task automatic pulse(input logic scan, input logic [15:0] v);
		@(posedge clk);
		rv <= !scan;
		sd <= scan;
		rdg <= v;
		@(posedge clk);
		rv <= 0;
		sd <= 0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) rdc(rows[i].a, rows[i].e);
		wrr(8'h1C, 32'h0000_0200);
		wrr(8'h00, 32'h0000_0080);
		pulse(0, 16'hA5C3);
		outs(4'h0);
		wrr(8'h00, 32'h0000_0010);
		pulse(0, 16'h1234);
		outs(4'hA);
		chk({31'h0, n_srq > 0}, 32'h0000_0001);
		rdc(8'h0C, 32'h0000_0006);
		want = 8'h14;
		repeat (4) @(posedge clk);
		rdc(8'h0C, 32'h0000_0002);
		want = 8'h00;
		rdc(8'h08, 32'h0000_A5C3);
		outs(4'hA);
		rdc(8'h08, 32'h0000_1234);
		outs(4'h0);
		wrr(8'h00, 32'h0000_0001);
		wrr(8'h00, 32'h0000_0011);
		outs(4'hA);
		wrr(8'h00, 32'h0000_0005);
		outs(4'h0);
		wrr(8'h00, 32'h0000_0015);
		outs(4'h4);
		wrr(8'h00, 32'h0000_0035);
		outs(4'h0);
		wrr(8'h20, 32'h0000_000F);
		wrr(8'h24, 32'h0000_0002);
		wrr(8'h00, 32'h0000_0003);
		wrr(8'h00, 32'h0000_0013);
		pulse(1, 16'h0000);
		outs(4'hB);
		rdc(8'h20, 32'h0000_0003);
		wrr(8'h20, 32'h0000_0003);
		outs(4'hA);
		rdc(8'h00, 32'h0000_010B);
		wrr(8'h10, 32'h0000_2001);
		wrr(8'h00, 32'h0000_0093);
		rdc(8'h20, 32'h0000_0008);
		rdc(8'h00, 32'h0000_010B);
		wrr(8'h10, 32'h0000_0005);
		wrr(8'h00, 32'h0000_0042);
		rdc(8'h10, 32'h0000_0001);
		wrr(8'h10, 32'h0000_0007);
		rdc(8'h10, 32'h0000_0007);
		wrr(8'h00, 32'h0000_0092);
		pulse(0, 16'h0042);
		outs(4'h0);
		pulse(1, 16'h0000);
		outs(4'hB);
		// A low clock enable must freeze every register, so this write has to vanish.
		@(posedge clk);
		ce <= 0;
		wrr(8'h1C, 32'h0000_0000);
		@(posedge clk);
		ce <= 1;
		rdc(8'h1C, 32'h0000_0200);
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rdc(8'h00, 32'h0000_0100);
		rdc(8'h1C, 32'h0000_0000);
		outs(4'h0);
		test_done();
	end
endmodule // reading_store_interrupt_logic_test
